// ---- hw/ppl_pkg.sv ----
// Constants for the timestamp-unit bank selector, latency and asymmetry registers.
// Assumes byte addresses on a 12-bit register port with 32-bit data.
package ppl_pkg;

    localparam int          ADDR_W          = 12;
    localparam int          NUM_PORTS       = 3;
    localparam int          PORT_W          = 2;

    // Register byte offsets.
    localparam logic [11:0] OFF_SELECTOR    = 12'h154;
    localparam logic [11:0] OFF_LATENCY     = 12'h158;
    localparam logic [11:0] OFF_ASYM_PEER   = 12'h15C;

    // Selector field positions.
    localparam int          GPIO_SEL_LSB    = 8;
    localparam int          GPIO_SEL_W      = 3;
    localparam int          PORT_SEL_LSB    = 4;
    localparam int          BANK_SEL_LSB    = 0;
    localparam int          BANK_SEL_W      = 3;

    // Bank codes; any code with the top bit set is reserved.
    localparam logic [2:0]  BANK_GENERAL    = 3'h0;
    localparam logic [2:0]  BANK_RX         = 3'h1;
    localparam logic [2:0]  BANK_TX         = 3'h2;
    localparam logic [2:0]  BANK_GPIO       = 3'h3;

    // Latency and asymmetry field positions.
    localparam int          HI_LSB          = 16;
    localparam int          HALF_W          = 16;

    // Reset values.
    localparam logic [2:0]  RST_GPIO_SEL    = 3'h0;
    localparam logic [1:0]  RST_PORT_SEL    = 2'h0;
    localparam logic [2:0]  RST_BANK_SEL    = 3'h0;
    localparam logic [15:0] RST_LAT_HOST    = 16'h0014;
    localparam logic [15:0] RST_EGRESS_EXT  = 16'h005F;
    localparam logic [15:0] RST_INGRESS_EXT = 16'h011D;
    localparam logic [15:0] RST_ASYM        = 16'h0000;
    localparam logic [15:0] RST_PEER        = 16'h0000;

    // Receive parsing configuration: writable width and reset value.
    localparam int          PARSE_W         = 15;
    localparam logic [14:0] RST_PARSE       = 15'h7100;

    // Timestamp arithmetic.
    localparam int          NS_W            = 30;
    localparam logic [30:0] NS_PER_SEC      = 31'h3B9ACA00;

endpackage

// ---- hw/ppl_regs.sv ----
// Bank/port/GPIO selector, per-port latency and per-port asymmetry/peer-delay
// registers of the timestamp unit, plus the latency correction of captured times.
// Assumes a single-cycle register port on clk_i and capture strobes from logic
// on the same clock.
//
// How it works
// - Selector bits 10:8 pick the GPIO the GPIO window reaches; reset zero.
// - Selector bits 5:4 pick the port the port window reaches; reset zero.
// - Selector bits 2:0 pick bank: general, receive, transmit, GPIO; 1xx reserved.
// - Port registers sit in one range, decoded by the bank field; the transmit and GPIO banks reach none.
// - Latency bits 31:16 hold egress delay in ns, read/write.
// - Latency bits 15:0 hold ingress delay in ns, read/write.
// - Captured clock values are corrected by latency to mark the wire symbol.
// - External ports reset latency to egress 95, ingress 285.
// - Host port resets both latency fields to 20.
// - Asymmetry register bits 31:16 hold path asymmetry in ns, reset zero.
// - Asymmetry is signed two's complement in all arithmetic.
// - Positive asymmetry means the forward path is slower than the reverse.
// - Asymmetry register bits 15:0 hold measured peer delay in ns, reset zero.
// - Latency offset in the receive bank reaches the receive parsing register.
`timescale 1ns/10ps

module ppl_regs (
    input  wire logic                      clk_i,
    input  wire logic                      rst_i,
    input  wire logic [ppl_pkg::ADDR_W-1:0] addr_i,
    input  wire logic [31:0]               wdata_i,
    input  wire logic                      wr_i,
    input  wire logic                      rd_i,
    output logic      [31:0]               rdata_o,
    input  wire logic                      cap_valid_i,
    input  wire logic [1:0]                cap_port_i,
    input  wire logic                      cap_egress_i,
    input  wire logic [31:0]               cap_sec_i,
    input  wire logic [29:0]               cap_ns_i,
    output logic                           ts_valid_o,
    output logic      [1:0]                ts_port_o,
    output logic                           ts_egress_o,
    output logic      [31:0]               ts_sec_o,
    output logic      [29:0]               ts_ns_o,
    output logic signed [31:0]             ts_m2s_delay_o,
    output logic      [2:0]                gpio_sel_o,
    output logic      [2:0]                bank_sel_o,
    output logic      [1:0]                port_sel_o
);

    typedef struct packed {
        logic [2:0]        gpio_sel;
        logic [1:0]        port_sel;
        logic [2:0]        bank_sel;
        logic [2:0][15:0]  lat_eg;
        logic [2:0][15:0]  lat_in;
        logic [2:0][15:0]  asym;
        logic [2:0][15:0]  peer;
        logic [2:0][14:0]  parse;
        logic [31:0]       rdata;
        logic              ts_valid;
        logic [1:0]        ts_port;
        logic              ts_egress;
        logic [31:0]       ts_sec;
        logic [29:0]       ts_ns;
        logic signed [31:0] m2s;
    } ppl_state_s;

    ppl_state_s st_r;
    ppl_state_s st_nxt;

    logic [ppl_pkg::PORT_W-1:0] cap_idx;
    logic                       cap_ok;
    logic [30:0]                ns_ext;
    logic [30:0]                lat_ext;
    logic [30:0]                ns_sum;
    logic [30:0]                ns_dif;
    logic signed [31:0]         asym_sx;
    logic signed [31:0]         peer_zx;

    // Reset image built from package constants, port 0 being the host port.
    function automatic ppl_state_s reset_image();
        ppl_state_s s;
        s          = '0;
        s.gpio_sel = ppl_pkg::RST_GPIO_SEL;
        s.port_sel = ppl_pkg::RST_PORT_SEL;
        s.bank_sel = ppl_pkg::RST_BANK_SEL;
        for (int p = 0; p < ppl_pkg::NUM_PORTS; p++) begin
            s.lat_eg[p] = (p == 0) ? ppl_pkg::RST_LAT_HOST : ppl_pkg::RST_EGRESS_EXT;
            s.lat_in[p] = (p == 0) ? ppl_pkg::RST_LAT_HOST : ppl_pkg::RST_INGRESS_EXT;
            s.asym[p]   = ppl_pkg::RST_ASYM;
            s.peer[p]   = ppl_pkg::RST_PEER;
            s.parse[p]  = ppl_pkg::RST_PARSE;
        end
        return s;
    endfunction

    // Window decode uses the selected port; port code 3 reaches nothing.
    logic [1:0] wp;
    logic       wp_ok;
    logic       bank_gen;
    logic       bank_rx;

    assign wp       = st_r.port_sel;
    assign wp_ok    = (st_r.port_sel < 2'(ppl_pkg::NUM_PORTS));
    assign bank_gen = (st_r.bank_sel == ppl_pkg::BANK_GENERAL);
    assign bank_rx  = (st_r.bank_sel == ppl_pkg::BANK_RX);

    // Capture correction operands.
    assign cap_idx = cap_port_i;
    assign cap_ok  = (cap_port_i < 2'(ppl_pkg::NUM_PORTS));
    assign ns_ext  = {1'b0, cap_ns_i};
    assign lat_ext = cap_ok ? (cap_egress_i ? {15'h0000, st_r.lat_eg[cap_idx]}
                                            : {15'h0000, st_r.lat_in[cap_idx]})
                            : 31'h00000000;
    assign ns_sum  = ns_ext + lat_ext;
    assign ns_dif  = ns_ext - lat_ext;
    // Asymmetry is signed; peer delay is an unsigned magnitude.
    assign asym_sx = cap_ok ? 32'(signed'(st_r.asym[cap_idx])) : 32'sh00000000;
    assign peer_zx = cap_ok ? signed'({16'h0000, st_r.peer[cap_idx]}) : 32'sh00000000;

    always_comb begin
        st_nxt          = st_r;
        st_nxt.rdata    = 32'h00000000;
        st_nxt.ts_valid = 1'b0;

        // Register writes.
        if (wr_i) begin
            unique case (addr_i)
                ppl_pkg::OFF_SELECTOR: begin
                    // Only the defined fields are stored; reserved bits are dropped.
                    st_nxt.gpio_sel = wdata_i[ppl_pkg::GPIO_SEL_LSB +: ppl_pkg::GPIO_SEL_W];
                    st_nxt.port_sel = wdata_i[ppl_pkg::PORT_SEL_LSB +: ppl_pkg::PORT_W];
                    st_nxt.bank_sel = wdata_i[ppl_pkg::BANK_SEL_LSB +: ppl_pkg::BANK_SEL_W];
                end
                ppl_pkg::OFF_LATENCY: begin
                    if (wp_ok && bank_gen) begin
                        st_nxt.lat_eg[wp] = wdata_i[ppl_pkg::HI_LSB +: ppl_pkg::HALF_W];
                        st_nxt.lat_in[wp] = wdata_i[0 +: ppl_pkg::HALF_W];
                    end else if (wp_ok && bank_rx) begin
                        st_nxt.parse[wp] = wdata_i[ppl_pkg::PARSE_W-1:0];
                    end
                end
                ppl_pkg::OFF_ASYM_PEER: begin
                    if (wp_ok && bank_gen) begin
                        st_nxt.asym[wp] = wdata_i[ppl_pkg::HI_LSB +: ppl_pkg::HALF_W];
                        st_nxt.peer[wp] = wdata_i[0 +: ppl_pkg::HALF_W];
                    end
                end
                default: begin
                end
            endcase
        end

        // Register reads; unmapped addresses and reserved banks read zero.
        if (rd_i) begin
            unique case (addr_i)
                ppl_pkg::OFF_SELECTOR: begin
                    st_nxt.rdata[ppl_pkg::GPIO_SEL_LSB +: ppl_pkg::GPIO_SEL_W] = st_r.gpio_sel;
                    st_nxt.rdata[ppl_pkg::PORT_SEL_LSB +: ppl_pkg::PORT_W]     = st_r.port_sel;
                    st_nxt.rdata[ppl_pkg::BANK_SEL_LSB +: ppl_pkg::BANK_SEL_W] = st_r.bank_sel;
                end
                ppl_pkg::OFF_LATENCY: begin
                    if (wp_ok && bank_gen) begin
                        st_nxt.rdata = {st_r.lat_eg[wp], st_r.lat_in[wp]};
                    end else if (wp_ok && bank_rx) begin
                        st_nxt.rdata = {17'h00000, st_r.parse[wp]};
                    end
                end
                ppl_pkg::OFF_ASYM_PEER: begin
                    if (wp_ok && bank_gen) begin
                        st_nxt.rdata = {st_r.asym[wp], st_r.peer[wp]};
                    end
                end
                default: begin
                end
            endcase
        end

        // Timestamp correction, one cycle after the capture strobe.
        if (cap_valid_i) begin
            st_nxt.ts_valid  = 1'b1;
            st_nxt.ts_port   = cap_port_i;
            st_nxt.ts_egress = cap_egress_i;
            if (cap_egress_i) begin
                // Egress: the symbol reaches the wire after the stamp point.
                if (ns_sum >= ppl_pkg::NS_PER_SEC) begin
                    st_nxt.ts_ns  = 30'(ns_sum - ppl_pkg::NS_PER_SEC);
                    st_nxt.ts_sec = cap_sec_i + 32'h00000001;
                end else begin
                    st_nxt.ts_ns  = 30'(ns_sum);
                    st_nxt.ts_sec = cap_sec_i;
                end
            end else begin
                // Ingress: the symbol left the wire before the stamp point.
                if (ns_ext < lat_ext) begin
                    st_nxt.ts_ns  = 30'(ns_dif + ppl_pkg::NS_PER_SEC);
                    st_nxt.ts_sec = cap_sec_i - 32'h00000001;
                end else begin
                    st_nxt.ts_ns  = 30'(ns_dif);
                    st_nxt.ts_sec = cap_sec_i;
                end
            end
            // Forward path delay is the mean path plus the signed asymmetry.
            st_nxt.m2s = peer_zx + asym_sx;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_r <= reset_image();
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rdata_o        = st_r.rdata;
    assign ts_valid_o     = st_r.ts_valid;
    assign ts_port_o      = st_r.ts_port;
    assign ts_egress_o    = st_r.ts_egress;
    assign ts_sec_o       = st_r.ts_sec;
    assign ts_ns_o        = st_r.ts_ns;
    assign ts_m2s_delay_o = st_r.m2s;
    assign gpio_sel_o     = st_r.gpio_sel;
    assign bank_sel_o     = st_r.bank_sel;
    assign port_sel_o     = st_r.port_sel;

endmodule

// ---- verification/ppl_regs_props.sv ----
// Checker for the selector, window and capture ports of ppl_regs.
// Assumes one clock and the active-high asynchronous reset of the design.
`timescale 1ns/10ps
module ppl_regs_props (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic [11:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic        wr_i,
    input wire logic        rd_i,
    input wire logic [31:0] rdata_o,
    input wire logic        cap_valid_i,
    input wire logic [1:0]  cap_port_i,
    input wire logic        cap_egress_i,
    input wire logic [31:0] cap_sec_i,
    input wire logic [29:0] cap_ns_i,
    input wire logic        ts_valid_o,
    input wire logic [1:0]  ts_port_o,
    input wire logic        ts_egress_o,
    input wire logic [31:0] ts_sec_o,
    input wire logic [29:0] ts_ns_o,
    input wire logic signed [31:0] ts_m2s_delay_o,
    input wire logic [2:0]  gpio_sel_o,
    input wire logic [2:0]  bank_sel_o,
    input wire logic [1:0]  port_sel_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_sel_wr;
        wr_i && addr_i == ppl_pkg::OFF_SELECTOR;
    endsequence
    sequence s_win_rd;
        rd_i && addr_i == ppl_pkg::OFF_LATENCY && bank_sel_o >= 3'h2;
    endsequence
    a_gpio_field: assert property (s_sel_wr |=> gpio_sel_o == $past(wdata_i[10:8]))
        else $error("gpio select not loaded");
    a_port_field: assert property (s_sel_wr |=> port_sel_o == $past(wdata_i[5:4]))
        else $error("port select not loaded");
    a_bank_field: assert property (s_sel_wr |=> bank_sel_o == $past(wdata_i[2:0]))
        else $error("bank select not loaded");
    a_sel_hold: assert property (!(wr_i && addr_i == ppl_pkg::OFF_SELECTOR)
        |=> $stable({gpio_sel_o, port_sel_o, bank_sel_o}))
        else $error("selector changed without a write");
    a_sel_read: assert property (rd_i && addr_i == ppl_pkg::OFF_SELECTOR |=>
        rdata_o == {21'h0, $past(gpio_sel_o), 2'h0, $past(port_sel_o), 1'h0, $past(bank_sel_o)})
        else $error("selector readback wrong");
    a_bank_empty: assert property (s_win_rd |=> rdata_o == 32'h0)
        else $error("empty bank read not zero");
    a_rd_idle: assert property (!rd_i |=> rdata_o == 32'h0)
        else $error("read data outside answer cycle");
    a_ts_pulse: assert property (cap_valid_i |=> ts_valid_o
        && ts_port_o == $past(cap_port_i) && ts_egress_o == $past(cap_egress_i))
        else $error("capture not answered");
    a_ts_quiet: assert property (!cap_valid_i |=> !ts_valid_o)
        else $error("timestamp without capture");
    a_no_corr: assert property (cap_valid_i && cap_port_i == 2'h3 |=>
        ts_ns_o == $past(cap_ns_i) && ts_sec_o == $past(cap_sec_i) && ts_m2s_delay_o == 0)
        else $error("port 3 corrected");
endmodule
bind ppl_regs ppl_regs_props ppl_regs_props_inst (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .cap_valid_i(cap_valid_i),
    .cap_port_i(cap_port_i), .cap_egress_i(cap_egress_i), .cap_sec_i(cap_sec_i),
    .cap_ns_i(cap_ns_i), .ts_valid_o(ts_valid_o), .ts_port_o(ts_port_o),
    .ts_egress_o(ts_egress_o), .ts_sec_o(ts_sec_o), .ts_ns_o(ts_ns_o),
    .ts_m2s_delay_o(ts_m2s_delay_o), .gpio_sel_o(gpio_sel_o), .bank_sel_o(bank_sel_o),
    .port_sel_o(port_sel_o));

// ---- verification/ppl_regs_bench.sv ----
// Self-checking bench for the timestamp-unit register bank.
// Assumes ppl_pkg, ppl_regs and its checker are compiled first.
`timescale 1ns/10ps
module ppl_regs_bench;
    logic               clk_i = 1'b0, rst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0, rd_d = 1'b0;
    logic               cap_valid_i = 1'b0, cap_egress_i = 1'b0, ts_valid_o, ts_egress_o;
    logic        [11:0] addr_i = 12'h0;
    logic        [31:0] wdata_i = 32'h0, cap_sec_i = 32'h0, rdata_o, ts_sec_o, seed = 32'hACA6;
    logic        [29:0] cap_ns_i = 30'h0, ts_ns_o;
    logic signed [31:0] ts_m2s_delay_o;
    logic        [1:0]  cap_port_i = 2'h0, ts_port_o, port_sel_o;
    logic        [2:0]  gpio_sel_o, bank_sel_o;
    logic        [15:0] le[3] = '{16'h0014, 16'h005F, 16'h005F};
    logic        [15:0] li[3] = '{16'h0014, 16'h011D, 16'h011D};
    logic        [15:0] asy[3] = '{3{16'h0}}, pd[3] = '{3{16'h0}};
    logic        [31:0] rq[$];
    logic        [93:0] tq[$];
    int                 err_total = 0, samples_checked = 0, cyc = 0;
    ppl_regs ppl_regs_inst (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .cap_valid_i(cap_valid_i),
        .cap_port_i(cap_port_i), .cap_egress_i(cap_egress_i), .cap_sec_i(cap_sec_i),
        .cap_ns_i(cap_ns_i), .ts_valid_o(ts_valid_o), .ts_port_o(ts_port_o),
        .ts_egress_o(ts_egress_o), .ts_sec_o(ts_sec_o), .ts_ns_o(ts_ns_o),
        .ts_m2s_delay_o(ts_m2s_delay_o), .gpio_sel_o(gpio_sel_o), .bank_sel_o(bank_sel_o),
        .port_sel_o(port_sel_o));
    always #5 clk_i = ~clk_i;
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input logic [93:0] s, input logic [93:0] e);
        samples_checked++;
        if (s !== e) begin
            err_total++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic end_sim();
        $display("checked %0d, mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        @(posedge clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        rq.push_back(e);
        @(posedge clk_i);
        rd_i <= 1'b0;
    endtask
    task automatic cap(input logic [1:0] p, input logic e, input logic [29:0] n);
        logic [31:0] s;
        logic [31:0] m;
        longint      t;
        s = xs();
        t = n;
        m = 32'h0;
        @(posedge clk_i);
        cap_valid_i <= 1'b1;
        cap_port_i <= p;
        cap_egress_i <= e;
        cap_sec_i <= s;
        cap_ns_i <= n;
        if (p != 2'h3) begin
            t = e ? t + longint'(le[p]) : t - longint'(li[p]);
            m = {{16{asy[p][15]}}, asy[p]} + {16'h0, pd[p]};
        end
        if (t >= 64'sh3B9ACA00) begin
            t -= 64'sh3B9ACA00;
            s++;
        end else if (t < 0) begin
            t += 64'sh3B9ACA00;
            s--;
        end
        tq.push_back({s, t[29:0], m});
        @(posedge clk_i);
        cap_valid_i <= 1'b0;
    endtask
    always @(posedge clk_i) begin
        if (rd_d) begin
            chk(94'(rdata_o), rq.size() ? 94'(rq.pop_front()) : '1);
        end
        if (ts_valid_o !== 1'b0 && cyc > 0) begin
            chk({ts_sec_o, ts_ns_o, ts_m2s_delay_o}, tq.size() ? tq.pop_front() : '1);
        end
        rd_d <= rd_i;
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            err_total++;
            end_sim();
        end
    end
    initial begin
        logic [31:0] d;
        logic [29:0] n;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int p = 0; p < 3; p++) begin
            wr(12'h154, 32'(p) << 4);
            rd(12'h158, {le[p], li[p]});
            rd(12'h15C, 32'h0);
            wr(12'h154, (32'(p) << 4) | 32'h1);
            rd(12'h158, 32'h7100);
            rd(12'h15C, 32'h0);
        end
        $display("test reset values done");
        wr(12'h154, 32'hFFFFFFFF);
        rd(12'h154, 32'h00000737);
        rd(12'h160, 32'h0);
        for (int b = 2; b < 8; b++) begin
            wr(12'h154, 32'h10 | 32'(b));
            wr(12'h158, xs());
            rd(12'h158, 32'h0);
        end
        wr(12'h154, 32'h10);
        rd(12'h158, {le[1], li[1]});
        $display("test banks done");
        for (int p = 0; p < 3; p++) begin
            wr(12'h154, 32'(p) << 4);
            d = xs();
            wr(12'h158, d);
            le[p] = d[31:16];
            li[p] = d[15:0];
            d = xs();
            wr(12'h15C, d);
            asy[p] = d[31:16];
            pd[p] = d[15:0];
            rd(12'h158, {le[p], li[p]});
            rd(12'h15C, {asy[p], pd[p]});
        end
        wr(12'h154, 32'h21);
        wr(12'h158, 32'hFFFFFFFF);
        rd(12'h158, 32'h00007FFF);
        wr(12'h154, 32'h20);
        wr(12'h15C, 32'hFFF00020);
        asy[2] = 16'hFFF0;
        pd[2] = 16'h0020;
        rd(12'h158, {le[2], li[2]});
        wr(12'h154, 32'h10);
        wr(12'h158, 32'h0473068A);
        le[1] = 16'h0473;
        li[1] = 16'h068A;
        rd(12'h158, 32'h0473068A);
        $display("test registers done");
        for (int i = 0; i < 12; i++) begin
            n = (i % 3 == 0) ? 30'h3B9AC9F6 : (i % 3 == 1) ? 30'h3 : 30'(xs() % 32'h3B9ACA00);
            cap(2'(i), i[0], n);
        end
        repeat (4) @(posedge clk_i);
        $display("test capture done");
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        wr(12'h154, 32'h10);
        rd(12'h158, 32'h005F011D);
        rd(12'h15C, 32'h0);
        rd(12'h154, 32'h10);
        repeat (2) @(posedge clk_i);
        $display("test second reset done");
        chk(94'(rq.size() + tq.size()), 94'h0);
        end_sim();
    end
endmodule
